// ==== design/acc_ctrl.sv ====
/*
 acc_ctrl: per-channel converter configuration registers, start bits,
 converter clock divider, conversion timing and result capture.
 Assumes a plain register port with single-cycle strobes and an analog
 front end that presents its conversion result on ADC_RESULT at the end.
*/
// Operation
// - ch1 secondary: bias 6-4, reference 1-0
// - ch2 primary: gain, clock, resolution, offset
// - ch2 secondary: bias 6-4, reference 1-0
// - temperature primary uses same field layout
// - temperature secondary holds only bias 6-4
// - converter clock is 4MHz divided 4..512
// - resolution code selects bits and clocks
// - conversion lasts selected clocks at rate
// - offset is sign plus three magnitude
// - start bit converts, halts, self-clears
// - reference select picks converter reference
// - ch1 primary at 02h, standard layout
`timescale 1ns/1ps
`default_nettype none

module acc_ctrl
   import acc_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic [15:0] ADC_RESULT,
   output logic ADC_CLK,
   output logic CPU_HALT,
   output logic RESULT_STROBE,
   output logic [1:0] ADC_CHANNEL,
   output logic [4:0] ADC_GAIN,
   output logic [3:0] ADC_OFFSET,
   output logic [2:0] ADC_RES,
   output logic [2:0] ADC_BIAS,
   output logic [1:0] ADC_REF
);

   // primary word packing, unused bit 7 reads zero
   function automatic logic [15:0] prim_word(
      input logic [4:0] g,
      input logic [2:0] c,
      input logic [2:0] r,
      input logic [3:0] o
   );
      logic [15:0] w;
      w = 16'h0000;
      w[GAIN_LSB +: 5] = g;
      w[CLKSEL_LSB +: 3] = c;
      w[RES_LSB +: 3] = r;
      w[OFS_LSB +: 4] = o;
      return w;
   endfunction : prim_word

   // secondary word packing
   function automatic logic [15:0] sec_word(
      input logic [2:0] b,
      input logic [1:0] f
   );
      logic [15:0] w;
      w = 16'h0000;
      w[BIAS_LSB +: 3] = b;
      w[REF_LSB +: 2] = f;
      return w;
   endfunction : sec_word

   // last system tick of a converter half period
   function automatic logic [7:0] div_half_last(input logic [2:0] c);
      return 8'((DIV_HALF_BASE << c) - 9'h001);
   endfunction : div_half_last

   // last converter period of a conversion
   function automatic logic [11:0] conv_last(input logic [2:0] r);
      logic [11:0] n;
      n = CONV_CLOCKS_16B;
      unique case (r)
         3'h0: n = CONV_CLOCKS_9B;
         3'h1: n = CONV_CLOCKS_10B;
         3'h2: n = CONV_CLOCKS_12B;
         3'h3: n = CONV_CLOCKS_13B;
         3'h4: n = CONV_CLOCKS_14B;
         3'h5: n = CONV_CLOCKS_15B;
         3'h6: n = CONV_CLOCKS_16B;
         3'h7: n = CONV_CLOCKS_16B;
      endcase
      return n - 12'h001;
   endfunction : conv_last

   acc_state_e state;
   acc_state_e next_state;
   logic [4:0] gain [NUM_CH];
   logic [4:0] next_gain [NUM_CH];
   logic [2:0] clksel [NUM_CH];
   logic [2:0] next_clksel [NUM_CH];
   logic [2:0] res [NUM_CH];
   logic [2:0] next_res [NUM_CH];
   logic [3:0] ofs [NUM_CH];
   logic [3:0] next_ofs [NUM_CH];
   logic [2:0] bias [NUM_CH];
   logic [2:0] next_bias [NUM_CH];
   logic [1:0] refsel [NUM_CH];
   logic [1:0] next_refsel [NUM_CH];
   logic start_pend [NUM_CH];
   logic next_start_pend [NUM_CH];
   logic [15:0] result [NUM_CH];
   logic [15:0] next_result [NUM_CH];
   logic [15:0] next_rdata;
   logic [1:0] next_channel;
   logic [2:0] cur_clksel;
   logic [2:0] next_cur_clksel;
   logic [2:0] pre_cnt;
   logic [2:0] next_pre_cnt;
   logic [7:0] div_cnt;
   logic [7:0] next_div_cnt;
   logic [11:0] per_cnt;
   logic [11:0] next_per_cnt;
   logic next_adc_clk;
   logic next_cpu_halt;
   logic next_result_strobe;
   logic [4:0] next_adc_gain;
   logic [3:0] next_adc_offset;
   logic [2:0] next_adc_res;
   logic [2:0] next_adc_bias;
   logic [1:0] next_adc_ref;

   // register file and read port
   always_comb begin
      next_rdata = 16'h0000;
      for (int i = 0; i < NUM_CH; i++) begin
         next_gain[i] = gain[i];
         next_clksel[i] = clksel[i];
         next_res[i] = res[i];
         next_ofs[i] = ofs[i];
         next_bias[i] = bias[i];
         next_refsel[i] = refsel[i];
         next_start_pend[i] = start_pend[i];
         if (state == ST_STORE && ADC_CHANNEL == 2'(i)) begin
            next_start_pend[i] = 1'b0;
         end
         // start bit set, wins over clear
         if (WR && ADDR == START_OFS && WDATA[START_BIT[i]]) begin
            next_start_pend[i] = 1'b1;
         end
         if (WR && ADDR == PRI_OFS[i]) begin
            next_gain[i] = WDATA[GAIN_LSB +: 5];
            next_clksel[i] = WDATA[CLKSEL_LSB +: 3];
            next_res[i] = WDATA[RES_LSB +: 3];
            next_ofs[i] = WDATA[OFS_LSB +: 4];
         end
         if (WR && ADDR == SEC_OFS[i]) begin
            next_bias[i] = WDATA[BIAS_LSB +: 3];
            if (i != TEMP_IDX) begin
               next_refsel[i] = WDATA[REF_LSB +: 2];
            end
         end
         if (RD && ADDR == START_OFS) begin
            next_rdata[START_BIT[i]] = start_pend[i];
         end
         if (RD && ADDR == PRI_OFS[i]) begin
            next_rdata = prim_word(gain[i], clksel[i], res[i], ofs[i]);
         end
         if (RD && ADDR == SEC_OFS[i]) begin
            next_rdata = sec_word(bias[i], refsel[i]);
         end
         if (RD && ADDR == DATA_OFS[i]) begin
            next_rdata = result[i];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         RDATA <= 16'h0000;
         for (int i = 0; i < NUM_CH; i++) begin
            gain[i] <= GAIN_RESET;
            clksel[i] <= CLKSEL_RESET;
            res[i] <= RES_RESET;
            ofs[i] <= OFS_RESET;
            bias[i] <= BIAS_RESET;
            refsel[i] <= REF_RESET;
            start_pend[i] <= 1'b0;
         end
      end else if (CE) begin
         RDATA <= next_rdata;
         for (int i = 0; i < NUM_CH; i++) begin
            gain[i] <= next_gain[i];
            clksel[i] <= next_clksel[i];
            res[i] <= next_res[i];
            ofs[i] <= next_ofs[i];
            bias[i] <= next_bias[i];
            refsel[i] <= next_refsel[i];
            start_pend[i] <= next_start_pend[i];
         end
      end
   end

   // conversion sequencer and converter clock
   always_comb begin
      next_state = state;
      next_channel = ADC_CHANNEL;
      next_cur_clksel = cur_clksel;
      next_pre_cnt = pre_cnt;
      next_div_cnt = div_cnt;
      next_per_cnt = per_cnt;
      next_adc_clk = ADC_CLK;
      next_cpu_halt = CPU_HALT;
      next_result_strobe = 1'b0;
      next_adc_gain = ADC_GAIN;
      next_adc_offset = ADC_OFFSET;
      next_adc_res = ADC_RES;
      next_adc_bias = ADC_BIAS;
      next_adc_ref = ADC_REF;
      for (int i = 0; i < NUM_CH; i++) begin
         next_result[i] = result[i];
      end
      unique case (state)
         ST_IDLE: begin
            if (start_pend[CH1_IDX] || start_pend[CH2_IDX] || start_pend[TEMP_IDX]) begin
               if (start_pend[CH1_IDX]) begin
                  next_channel = 2'(CH1_IDX);
               end else if (start_pend[CH2_IDX]) begin
                  next_channel = 2'(CH2_IDX);
               end else begin
                  next_channel = 2'(TEMP_IDX);
               end
               next_cur_clksel = clksel[next_channel];
               next_adc_gain = gain[next_channel];
               next_adc_offset = ofs[next_channel];
               next_adc_res = res[next_channel];
               next_adc_bias = bias[next_channel];
               next_adc_ref = (next_channel == 2'(TEMP_IDX)) ? TEMP_REF_FIXED
                                                              : refsel[next_channel];
               next_pre_cnt = 3'h0;
               next_div_cnt = 8'h00;
               next_per_cnt = 12'h000;
               next_adc_clk = 1'b0;
               next_cpu_halt = 1'b1;
               next_state = ST_CONV;
            end
         end
         ST_CONV: begin
            // prescale core clock to system clock
            if (pre_cnt == PRESCALE_LAST) begin
               next_pre_cnt = 3'h0;
               if (div_cnt == div_half_last(cur_clksel)) begin
                  next_div_cnt = 8'h00;
                  next_adc_clk = ~ADC_CLK;
                  if (ADC_CLK) begin
                     if (per_cnt == conv_last(ADC_RES)) begin
                        next_state = ST_STORE;
                     end else begin
                        next_per_cnt = per_cnt + 12'h001;
                     end
                  end
               end else begin
                  next_div_cnt = div_cnt + 8'h01;
               end
            end else begin
               next_pre_cnt = pre_cnt + 3'h1;
            end
         end
         ST_STORE: begin
            next_result[ADC_CHANNEL] = ADC_RESULT;
            next_result_strobe = 1'b1;
            next_cpu_halt = 1'b0;
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state <= ST_IDLE;
         ADC_CHANNEL <= 2'h0;
         cur_clksel <= CLKSEL_RESET;
         pre_cnt <= 3'h0;
         div_cnt <= 8'h00;
         per_cnt <= 12'h000;
         ADC_CLK <= 1'b0;
         CPU_HALT <= 1'b0;
         RESULT_STROBE <= 1'b0;
         ADC_GAIN <= GAIN_RESET;
         ADC_OFFSET <= OFS_RESET;
         ADC_RES <= RES_RESET;
         ADC_BIAS <= BIAS_RESET;
         ADC_REF <= REF_RESET;
         for (int i = 0; i < NUM_CH; i++) begin
            result[i] <= DATA_RESET;
         end
      end else if (CE) begin
         state <= next_state;
         ADC_CHANNEL <= next_channel;
         cur_clksel <= next_cur_clksel;
         pre_cnt <= next_pre_cnt;
         div_cnt <= next_div_cnt;
         per_cnt <= next_per_cnt;
         ADC_CLK <= next_adc_clk;
         CPU_HALT <= next_cpu_halt;
         RESULT_STROBE <= next_result_strobe;
         ADC_GAIN <= next_adc_gain;
         ADC_OFFSET <= next_adc_offset;
         ADC_RES <= next_adc_res;
         ADC_BIAS <= next_adc_bias;
         ADC_REF <= next_adc_ref;
         for (int i = 0; i < NUM_CH; i++) begin
            result[i] <= next_result[i];
         end
      end
   end

endmodule : acc_ctrl

`default_nettype wire

// ==== design/acc_pkg.sv ====
/*
 acc_pkg: register map, field layout, reset values, timing and states
 for the converter channel configuration block.
 Assumes a 20 MHz core clock and a 4 MHz converter system clock.
*/
package acc_pkg;

   // clock rates and prescaler from core clock to system clock
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned SYS_CLK_HZ = 4_000_000;
   localparam int unsigned PRESCALE = CLK_HZ / SYS_CLK_HZ;
   localparam logic [2:0] PRESCALE_LAST = 3'(PRESCALE - 1);

   // channel indices
   localparam int unsigned NUM_CH = 3;
   localparam int unsigned CH1_IDX = 0;
   localparam int unsigned CH2_IDX = 1;
   localparam int unsigned TEMP_IDX = 2;

   // register word offsets
   localparam logic [7:0] START_OFS = 8'h01;
   localparam logic [7:0] CH1_PRI_OFS = 8'h02;
   localparam logic [7:0] CH1_SEC_OFS = 8'h03;
   localparam logic [7:0] CH2_PRI_OFS = 8'h05;
   localparam logic [7:0] CH2_SEC_OFS = 8'h06;
   localparam logic [7:0] TEMP_PRI_OFS = 8'h08;
   localparam logic [7:0] TEMP_SEC_OFS = 8'h09;
   localparam logic [7:0] CH1_DATA_OFS = 8'h0A;
   localparam logic [7:0] CH2_DATA_OFS = 8'h0B;
   localparam logic [7:0] TEMP_DATA_OFS = 8'h0C;
   localparam logic [7:0] PRI_OFS [NUM_CH] = '{CH1_PRI_OFS, CH2_PRI_OFS, TEMP_PRI_OFS};
   localparam logic [7:0] SEC_OFS [NUM_CH] = '{CH1_SEC_OFS, CH2_SEC_OFS, TEMP_SEC_OFS};
   localparam logic [7:0] DATA_OFS [NUM_CH] = '{CH1_DATA_OFS, CH2_DATA_OFS, TEMP_DATA_OFS};

   // field positions
   localparam int unsigned GAIN_LSB = 11;
   localparam int unsigned CLKSEL_LSB = 8;
   localparam int unsigned RES_LSB = 4;
   localparam int unsigned OFS_LSB = 0;
   localparam int unsigned BIAS_LSB = 4;
   localparam int unsigned REF_LSB = 0;
   localparam int unsigned START_CH1_BIT = 2;
   localparam int unsigned START_CH2_BIT = 1;
   localparam int unsigned START_TEMP_BIT = 0;
   localparam int unsigned START_BIT [NUM_CH] = '{START_CH1_BIT, START_CH2_BIT, START_TEMP_BIT};

   // reset values
   localparam logic [4:0] GAIN_RESET = 5'h00;
   localparam logic [2:0] CLKSEL_RESET = 3'h0;
   localparam logic [2:0] RES_RESET = 3'h0;
   localparam logic [3:0] OFS_RESET = 4'h0;
   localparam logic [2:0] BIAS_RESET = 3'h0;
   localparam logic [1:0] REF_RESET = 2'h0;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [1:0] TEMP_REF_FIXED = 2'h0;

   // converter clocks per conversion for each resolution code
   localparam logic [11:0] CONV_CLOCKS_9B = 12'h100;
   localparam logic [11:0] CONV_CLOCKS_10B = 12'h140;
   localparam logic [11:0] CONV_CLOCKS_12B = 12'h200;
   localparam logic [11:0] CONV_CLOCKS_13B = 12'h280;
   localparam logic [11:0] CONV_CLOCKS_14B = 12'h320;
   localparam logic [11:0] CONV_CLOCKS_15B = 12'h500;
   localparam logic [11:0] CONV_CLOCKS_16B = 12'h800;
   localparam logic [8:0] DIV_HALF_BASE = 9'h002;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_STORE = 3'b100
   } acc_state_e;

endpackage : acc_pkg

// ==== tb/acc_adc_model.sv ====
/*
 acc_adc_model: converter core seen from the block, gives a result per channel.
 Assumes the result is taken while CPU_HALT is high.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_adc_model (
   input wire logic CLK,
   input wire logic CPU_HALT,
   input wire logic [1:0] ADC_CHANNEL,
   output logic [15:0] ADC_RESULT
);
   logic [15:0] idle_pat = 16'hA5C3;
   // idle bus carries junk that changes every cycle
   always @(posedge CLK) idle_pat <= ~idle_pat;
   assign ADC_RESULT = CPU_HALT ? 16'h5A00 + {14'h0000, ADC_CHANNEL} : idle_pat;
endmodule : acc_adc_model
`default_nettype wire

// ==== tb/acc_ctrl_assertions.sv ====
/*
 acc_ctrl_assertions: port-level checks of the converter configuration block.
 Assumes binding to acc_ctrl, one clock CLK and synchronous reset SRST.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_assertions
   import acc_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   input wire logic ADC_CLK,
   input wire logic CPU_HALT,
   input wire logic RESULT_STROBE,
   input wire logic [1:0] ADC_CHANNEL,
   input wire logic [4:0] ADC_GAIN,
   input wire logic [3:0] ADC_OFFSET,
   input wire logic [2:0] ADC_RES,
   input wire logic [2:0] ADC_BIAS,
   input wire logic [1:0] ADC_REF
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   logic clk_q;
   logic [11:0] n_rise;
   logic [11:0] next_n_rise;
   function automatic logic [11:0] conv_len(input logic [2:0] r);
      case (r)
         3'h0: return CONV_CLOCKS_9B;
         3'h1: return CONV_CLOCKS_10B;
         3'h2: return CONV_CLOCKS_12B;
         3'h3: return CONV_CLOCKS_13B;
         3'h4: return CONV_CLOCKS_14B;
         3'h5: return CONV_CLOCKS_15B;
         default: return CONV_CLOCKS_16B;
      endcase
   endfunction : conv_len
   // counts converter clock rises within one conversion
   always_comb begin
      next_n_rise = n_rise;
      if (!CPU_HALT)
         next_n_rise = 12'h000;
      else if (ADC_CLK && !clk_q)
         next_n_rise = n_rise + 12'h001;
   end
   always_ff @(posedge CLK) begin
      clk_q <= SRST ? 1'b0 : ADC_CLK;
      n_rise <= SRST ? 12'h000 : next_n_rise;
   end
   sequence s_start_req;
      CE && WR && ADDR == START_OFS && WDATA[2:0] != 3'h0 && !CPU_HALT ##1 CE;
   endsequence
   sequence s_done;
      $rose(RESULT_STROBE);
   endsequence
   AST_START_HALT: assert property (s_start_req |=> CPU_HALT)
      else $error("conversion did not start after a start write");
   AST_DONE_HALT: assert property (s_done |-> $fell(CPU_HALT))
      else $error("halt did not end with the result strobe");
   AST_STROBE_ONE: assert property (RESULT_STROBE && CE |=> !RESULT_STROBE)
      else $error("result strobe longer than one cycle");
   AST_CONV_CLOCKS: assert property (s_done |-> n_rise == conv_len(ADC_RES))
      else $error("converter clock count does not match resolution");
   AST_CLK_HALF: assert property ($changed(ADC_CLK) && CPU_HALT |=>
      ($stable(ADC_CLK) || !CPU_HALT) [*8])
      else $error("converter clock faster than divide by four");
   AST_IDLE_CLK: assert property (!CPU_HALT |-> !ADC_CLK)
      else $error("converter clock runs while idle");
   AST_CFG_HOLD: assert property (CPU_HALT && $past(CPU_HALT) |->
      $stable({ADC_CHANNEL, ADC_GAIN, ADC_OFFSET, ADC_RES, ADC_BIAS, ADC_REF}))
      else $error("converter settings changed mid conversion");
   AST_TEMP_REF: assert property (CPU_HALT && ADC_CHANNEL == 2'h2 |-> ADC_REF == 2'h0)
      else $error("temperature conversion with a reference select");
   AST_RD_IDLE: assert property (CE && !RD |=> RDATA == 16'h0000)
      else $error("read data outside the read answer cycle");
endmodule : acc_ctrl_assertions
bind acc_ctrl acc_ctrl_assertions chk_u (.CLK(CLK), .SRST(SRST), .CE(CE), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ADC_CLK(ADC_CLK), .CPU_HALT(CPU_HALT),
   .RESULT_STROBE(RESULT_STROBE), .ADC_CHANNEL(ADC_CHANNEL), .ADC_GAIN(ADC_GAIN),
   .ADC_OFFSET(ADC_OFFSET), .ADC_RES(ADC_RES), .ADC_BIAS(ADC_BIAS), .ADC_REF(ADC_REF));
`default_nettype wire

// ==== tb/tb_acc_ctrl.sv ====
/*
 tb_acc_ctrl: self-checking bench for acc_ctrl with the converter model.
 Assumes a 50 ns clock and conversions at clock codes 0 and 1.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_acc_ctrl
   import acc_pkg::*;
;
   logic clk = 1'b0, srst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata, adc_result;
   logic adc_clk, halt, strobe;
   logic [1:0] chan, ref_sel;
   logic [4:0] gain;
   logic [3:0] ofs;
   logic [2:0] res, bias;
   int n_fail = 0;
   int compares = 0;
   acc_ctrl dut_u (.CLK(clk), .SRST(srst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .ADC_RESULT(adc_result), .ADC_CLK(adc_clk), .CPU_HALT(halt),
      .RESULT_STROBE(strobe), .ADC_CHANNEL(chan), .ADC_GAIN(gain), .ADC_OFFSET(ofs),
      .ADC_RES(res), .ADC_BIAS(bias), .ADC_REF(ref_sel));
   acc_adc_model adc_u (.CLK(clk), .CPU_HALT(halt), .ADC_CHANNEL(chan),
      .ADC_RESULT(adc_result));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp, input string what);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      cmp(rdata, exp, what);
   endtask : rd_reg
   task automatic conv_check(input logic [1:0] ch, input logic [15:0] pri,
      input logic [15:0] sec, input int len);
      int n;
      n = 0;
      #1;
      while (halt !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      cmp({14'h0000, chan}, {14'h0000, ch}, "channel");
      n = 0;
      while (halt === 1'b1 && n < 300000) begin
         @(posedge clk);
         #1;
         n++;
      end
      cmp({15'h0000, strobe}, 16'h0001, "strobe");
      cmp({15'h0000, n >= len - 3 && n <= len + 3}, 16'h0001, "length");
      cmp({1'b0, gain, ofs, res, bias}, {1'b0, pri[15:11], pri[3:0], pri[6:4], sec[6:4]},
         "cfg");
      cmp({14'h0000, ref_sel}, {14'h0000, (ch == 2'h2) ? 2'h0 : sec[1:0]}, "ref");
   endtask : conv_check
   task automatic test_regs;
      for (int i = 0; i < 3; i++) begin
         rd_reg(DATA_OFS[i], 16'h0000, "data reset");
         wr_reg(PRI_OFS[i], 16'hF7FF);
         rd_reg(PRI_OFS[i], 16'hF77F, "primary");
         wr_reg(SEC_OFS[i], 16'hFFFF);
         rd_reg(SEC_OFS[i], (i == 2) ? 16'h0070 : 16'h0073, "secondary");
         wr_reg(DATA_OFS[i], 16'hFFFF);
         rd_reg(DATA_OFS[i], 16'h0000, "data write");
      end
      wr_reg(8'h04, 16'hFFFF);
      rd_reg(8'h04, 16'h0000, "unmapped");
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(CH1_PRI_OFS, 16'h0000);
      ce <= 1'b1;
      rd_reg(CH1_PRI_OFS, 16'hF77F, "ce low write");
      $display("test_regs done");
   endtask : test_regs
   task automatic test_chain;
      // defined gains, bias fast enough for 1M, no supply reference
      // external and bandgap references only
      wr_reg(CH1_PRI_OFS, 16'hF007);
      wr_reg(CH1_SEC_OFS, 16'h0061);
      wr_reg(CH2_PRI_OFS, 16'h001F);
      wr_reg(CH2_SEC_OFS, 16'h0072);
      wr_reg(TEMP_PRI_OFS, 16'h5008);
      wr_reg(TEMP_SEC_OFS, 16'h0073);
      wr_reg(START_OFS, 16'h0007);
      conv_check(2'h0, 16'hF007, 16'h0061, 256 * 20);
      conv_check(2'h1, 16'h001F, 16'h0072, 320 * 20);
      conv_check(2'h2, 16'h5008, 16'h0070, 256 * 20);
      for (int i = 0; i < 3; i++) begin
         rd_reg(DATA_OFS[i], 16'h5A00 + 16'(i), "result");
      end
      rd_reg(START_OFS, 16'h0000, "start clear");
      $display("test_chain done");
   endtask : test_chain
   task automatic test_freeze;
      wr_reg(CH2_PRI_OFS, 16'h0900);
      wr_reg(CH2_SEC_OFS, 16'h0063);
      wr_reg(START_OFS, 16'h0002);
      repeat (4) @(posedge clk);
      wr_reg(CH2_PRI_OFS, 16'hF007);
      conv_check(2'h1, 16'h0900, 16'h0063, 256 * 40 - 5);
      rd_reg(CH2_PRI_OFS, 16'hF007, "late write");
      $display("test_freeze done");
   endtask : test_freeze
   task automatic test_reset;
      wr_reg(START_OFS, 16'h0004);
      repeat (15) @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #1;
      cmp({13'h0000, halt, adc_clk, strobe}, 16'h0000, "reset outputs");
      cmp({1'b0, gain, ofs, res, bias}, 16'h0000, "reset cfg");
      cmp({12'h000, chan, ref_sel}, 16'h0000, "reset chan");
      cmp(rdata, 16'h0000, "reset rdata");
      for (int i = 0; i < 3; i++) begin
         rd_reg(PRI_OFS[i], 16'h0000, "primary reset");
         rd_reg(SEC_OFS[i], 16'h0000, "secondary reset");
         rd_reg(DATA_OFS[i], 16'h0000, "result reset");
      end
      rd_reg(START_OFS, 16'h0000, "start reset");
      $display("test_reset done");
   endtask : test_reset
   task automatic give_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      test_regs();
      test_chain();
      test_freeze();
      test_reset();
      give_verdict();
   end
   initial begin
      #(60000 * 50);
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
endmodule : tb_acc_ctrl
`default_nettype wire
